// >>> pkg/eew_pkg.sv
package eew_pkg;
	// control register location and field positions
	localparam logic [7:0] CTRL_OFFSET = 8'hDF;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam int         STANDBY_BIT = 6;
	localparam int         START_BIT   = 3;
	localparam int         MODE_BIT    = 2;
	localparam int         BUSY_BIT    = 1;
	localparam int         ENABLE_BIT  = 0;

	// array contents
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] ABORT_DATA  = 8'h00;
	localparam int         ROW_BYTES   = 8;
	localparam int         LANE_W      = 3;
	localparam int         EE_ADDR_W   = 7;

	// programming time, least time so rounded up
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_TIME_NS  = 10000;
	localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       ee_sel;
		logic [7:0] addr;
		logic [7:0] wdata;
	} eew_req_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_PROG = 2'b10
	} eew_state_type;

	typedef logic [ROW_BYTES-1:0][7:0] eew_row_type;
endpackage : eew_pkg

// >>> design/eew_mem.sv
`timescale 1ns/10ps
module eew_mem
	import eew_pkg::*;
#(
	parameter int ADDR_W = EE_ADDR_W
)
(
	input  wire logic                     clk,
	input  wire logic                     rd_en,
	input  wire logic [ADDR_W-1:0]        rd_addr,
	output logic      [7:0]               rd_data,
	input  wire logic                     wr_en,
	input  wire logic [ADDR_W-LANE_W-1:0] wr_row,
	input  wire logic [ROW_BYTES-1:0]     wr_mask,
	input  wire eew_row_type              wr_data
);
	logic [7:0] cells [0:(2**ADDR_W)-1];

	// delivered erased; no reset, contents are nonvolatile
	initial
	begin
		for (int i = 0; i < 2**ADDR_W; i++)
			cells[i] = ERASED_BYTE; // RULE_15
	end

	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			for (int i = 0; i < ROW_BYTES; i++)
				if (wr_mask[i])
					cells[{wr_row, i[LANE_W-1:0]}] <= wr_data[i]; // RULE_04
		end
	end

	always_ff @(posedge clk)
	begin
		if (rd_en)
			rd_data <= cells[rd_addr];
	end
endmodule : eew_mem

// >>> design/eew_ctrl.sv
`timescale 1ns/10ps
// How it works
// RULE_01: standby bit disables the array, aborts accesses and cuts array power.
// RULE_02: setting start in row mode programs all loaded row bytes together.
// RULE_03: start bit clears itself when programming finishes.
// RULE_04: row bytes not loaded keep their previous contents.
// RULE_05: with row mode set and start clear, up to eight row bytes load.
// RULE_06: a row is address bits down to A3; A2..A0 pick the byte.
// RULE_07: row mode bit clears itself when a row cycle completes.
// RULE_08: clearing row mode before start abandons the cycle, array untouched.
// RULE_09: read-only busy flag is high throughout a programming cycle.
// RULE_10: accesses while busy are aborted; the running cycle still finishes.
// RULE_11: software polls busy before every array read or write.
// RULE_12: without program enable, array writes start no cycle.
// RULE_13: software sets program enable before writing the array.
// RULE_14: software writes the control register as a whole byte only.
// RULE_15: unprogrammed array bytes read FFh.
// RULE_16: setting row mode clears all eight row latches.
// RULE_17: first row access latches the row; other rows are errors.
// RULE_18: start is ignored unless enable and row mode are already set.
// RULE_19: control writes are rejected while busy.
// RULE_20: enabled write outside row mode programs one byte with busy high.
module eew_ctrl
	import eew_pkg::*;
#(
	parameter int ADDR_W = EE_ADDR_W,
	parameter int PROG_CNT = PROG_CYCLES
)
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire eew_req_type cpu_req,
	output logic      [7:0]  cpu_rdata,
	output logic             cpu_rvalid,
	output logic             access_error,
	output logic             program_busy_flag,
	output logic             array_standby
);
	localparam int ROW_W = ADDR_W - LANE_W;
	localparam int CNT_W = $clog2(PROG_CNT + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PROG_CNT - 1);

	eew_state_type          state_reg;
	logic                   program_enable_reg;
	logic                   row_mode_enable_reg;
	logic                   row_program_start_reg;
	logic                   par_cycle_reg;
	logic                   row_valid_reg;
	logic [ROW_W-1:0]       row_reg;
	logic [ROW_BYTES-1:0]   load_mask_reg;
	eew_row_type            latch_reg;
	logic [CNT_W-1:0]       prog_cnt_reg;
	logic                   rd_pend_reg;
	logic                   rd_ctrl_reg;
	logic                   rd_abort_reg;
	logic [7:0]             ctrl_rd_reg;
	logic [7:0]             mem_rdata;

	logic                   ctrl_wr;
	logic                   ctrl_rd;
	logic                   ee_wr;
	logic                   ee_rd;
	logic                   busy;
	logic                   ctrl_ok;
	logic                   start_ok;
	logic                   byte_ok;
	logic                   load_ok;
	logic                   row_hit;
	logic                   ee_blocked;
	logic                   prog_done;
	logic [ADDR_W-1:0]      ee_addr;
	logic [ROW_W-1:0]       ee_row;
	logic [LANE_W-1:0]      ee_lane;
	logic [7:0]             wd;

	assign wd       = cpu_req.wdata;
	assign ee_addr  = cpu_req.addr[ADDR_W-1:0];
	assign ee_row   = ee_addr[ADDR_W-1:LANE_W]; // RULE_06
	assign ee_lane  = ee_addr[LANE_W-1:0];      // RULE_06
	assign ctrl_wr  = cpu_req.wr && !cpu_req.ee_sel && (cpu_req.addr == CTRL_OFFSET);
	assign ctrl_rd  = cpu_req.rd && !cpu_req.ee_sel && (cpu_req.addr == CTRL_OFFSET);
	assign ee_wr    = cpu_req.wr && cpu_req.ee_sel;
	assign ee_rd    = cpu_req.rd && cpu_req.ee_sel;
	assign busy     = (state_reg == ST_PROG);
	assign prog_done = busy && (prog_cnt_reg == CNT_LAST);
	assign ctrl_ok  = ctrl_wr && !busy; // RULE_19
	// start needs enable and row mode set before this write, and row mode kept
	assign start_ok = ctrl_ok && wd[START_BIT] && wd[MODE_BIT]
		&& program_enable_reg && row_mode_enable_reg; // RULE_18
	assign ee_blocked = array_standby || busy; // RULE_01 RULE_10
	assign row_hit  = !row_valid_reg || (row_reg == ee_row); // RULE_17
	assign load_ok  = ee_wr && !ee_blocked && program_enable_reg
		&& row_mode_enable_reg && !row_program_start_reg && row_hit; // RULE_05
	assign byte_ok  = ee_wr && !ee_blocked && program_enable_reg
		&& !row_mode_enable_reg; // RULE_12 RULE_20

	// sequencer: one programming cycle of fixed length
	always_ff @(posedge clk)
	begin
		if (reset)
			state_reg <= ST_IDLE;
		else
		begin
			unique case (state_reg)
				ST_IDLE:
					if (start_ok || byte_ok)
						state_reg <= ST_PROG; // RULE_02 RULE_20
				ST_PROG:
					if (prog_done)
						state_reg <= ST_IDLE; // RULE_10
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			prog_cnt_reg <= '0;
		else if (busy)
			prog_cnt_reg <= prog_done ? '0 : prog_cnt_reg + CNT_W'(1);
		else
			prog_cnt_reg <= '0;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			program_busy_flag <= CTRL_RESET[BUSY_BIT];
		else if (start_ok || byte_ok)
			program_busy_flag <= 1'b1; // RULE_09
		else if (prog_done)
			program_busy_flag <= 1'b0; // RULE_09
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			par_cycle_reg <= 1'b0;
		else if (start_ok)
			par_cycle_reg <= 1'b1;
		else if (byte_ok)
			par_cycle_reg <= 1'b0;
	end

	// control register fields, all write only except busy
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			array_standby      <= CTRL_RESET[STANDBY_BIT];
			program_enable_reg <= CTRL_RESET[ENABLE_BIT];
		end
		else if (ctrl_ok)
		begin
			array_standby      <= wd[STANDBY_BIT]; // RULE_01
			program_enable_reg <= wd[ENABLE_BIT];  // RULE_12
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			row_mode_enable_reg <= CTRL_RESET[MODE_BIT];
		else if (prog_done && par_cycle_reg)
			row_mode_enable_reg <= 1'b0; // RULE_07
		else if (ctrl_ok)
			row_mode_enable_reg <= wd[MODE_BIT]; // RULE_08
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			row_program_start_reg <= CTRL_RESET[START_BIT];
		else if (prog_done)
			row_program_start_reg <= 1'b0; // RULE_03
		else if (start_ok)
			row_program_start_reg <= 1'b1; // RULE_02
	end

	// row address latch
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			row_valid_reg <= 1'b0;
			row_reg       <= '0;
		end
		else if (prog_done || (ctrl_ok && (wd[MODE_BIT] != row_mode_enable_reg)))
			row_valid_reg <= 1'b0; // RULE_08 RULE_16
		else if (load_ok && !row_valid_reg)
		begin
			row_valid_reg <= 1'b1; // RULE_17
			row_reg       <= ee_row;
		end
		else if (byte_ok)
			row_reg <= ee_row; // RULE_20
	end

	// volatile row latches, one per byte lane
	for (genvar i = 0; i < ROW_BYTES; i++)
	begin : g_lane
		logic hit;
		assign hit = (ee_lane == LANE_W'(i));

		always_ff @(posedge clk)
		begin
			if (reset)
			begin
				load_mask_reg[i] <= 1'b0;
				latch_reg[i]     <= ERASED_BYTE;
			end
			else if (prog_done || (ctrl_ok && (wd[MODE_BIT] != row_mode_enable_reg)))
			begin
				// entering or leaving row mode empties the latches
				load_mask_reg[i] <= 1'b0; // RULE_16 RULE_08
				latch_reg[i]     <= ERASED_BYTE;
			end
			else if (byte_ok)
			begin
				load_mask_reg[i] <= hit; // RULE_20
				latch_reg[i]     <= wd;
			end
			else if (load_ok && hit)
			begin
				load_mask_reg[i] <= 1'b1; // RULE_05
				latch_reg[i]     <= wd;
			end
		end
	end

	// array is written only at the end, so an abandoned row never touches it
	eew_mem #(
		.ADDR_W (ADDR_W)
	) eew_mem_inst (
		.clk     (clk),
		.rd_en   (ee_rd && !ee_blocked), // RULE_01
		.rd_addr (ee_addr),
		.rd_data (mem_rdata),
		.wr_en   (prog_done),
		.wr_row  (row_reg),
		.wr_mask (load_mask_reg), // RULE_04
		.wr_data (latch_reg)
	);

	// errors: aborted accesses and row-mode writes outside the latched row
	always_ff @(posedge clk)
	begin
		if (reset)
			access_error <= 1'b0;
		else
			access_error <= ((ee_wr || ee_rd) && ee_blocked) // RULE_10
				|| (ee_wr && !ee_blocked && program_enable_reg
				&& row_mode_enable_reg && !row_hit); // RULE_17
	end

	// read path: two cycles, array read data is registered in the memory
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rd_pend_reg  <= 1'b0;
			rd_ctrl_reg  <= 1'b0;
			rd_abort_reg <= 1'b0;
			ctrl_rd_reg  <= CTRL_RESET;
		end
		else
		begin
			rd_pend_reg  <= ctrl_rd || ee_rd;
			rd_ctrl_reg  <= ctrl_rd;
			rd_abort_reg <= ee_rd && ee_blocked;
			// only busy reads back; write-only fields read zero
			ctrl_rd_reg  <= 8'(program_busy_flag) << BUSY_BIT; // RULE_09
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cpu_rvalid <= 1'b0;
			cpu_rdata  <= 8'h00;
		end
		else
		begin
			cpu_rvalid <= rd_pend_reg;
			if (rd_ctrl_reg)
				cpu_rdata <= ctrl_rd_reg;
			else if (rd_abort_reg)
				cpu_rdata <= ABORT_DATA; // RULE_01 RULE_10
			else if (rd_pend_reg)
				cpu_rdata <= mem_rdata;
		end
	end

	busy_start_a: assert property (@(posedge clk) disable iff (reset) // RULE_02
		start_ok |=> program_busy_flag && row_program_start_reg)
		else $error("start did not raise busy");
	busy_len_a: assert property (@(posedge clk) disable iff (reset) // RULE_09
		$fell(program_busy_flag) |-> $past(prog_cnt_reg) == CNT_LAST)
		else $error("busy length wrong");
	start_clear_a: assert property (@(posedge clk) disable iff (reset) // RULE_03
		$fell(program_busy_flag) |-> !row_program_start_reg)
		else $error("start not cleared at end");
	mode_clear_a: assert property (@(posedge clk) disable iff (reset) // RULE_07
		$fell(program_busy_flag) && $past(par_cycle_reg) |-> !row_mode_enable_reg)
		else $error("row mode not cleared at end");
	latch_clear_a: assert property (@(posedge clk) disable iff (reset) // RULE_16
		ctrl_ok && wd[MODE_BIT] && !row_mode_enable_reg |=> load_mask_reg == '0)
		else $error("row latches not cleared");
	abandon_a: assert property (@(posedge clk) disable iff (reset) // RULE_08
		ctrl_ok && !wd[MODE_BIT] && row_mode_enable_reg |=> !program_busy_flag
		&& !row_mode_enable_reg && load_mask_reg == '0)
		else $error("abandon failed");
	ctrl_reject_a: assert property (@(posedge clk) disable iff (reset) // RULE_19
		ctrl_wr && busy |=> $stable(program_enable_reg) && $stable(array_standby))
		else $error("control written while busy");
	no_enable_a: assert property (@(posedge clk) disable iff (reset) // RULE_12
		ee_wr && !program_enable_reg && !busy |=> !program_busy_flag)
		else $error("write cycle without enable");
	busy_abort_a: assert property (@(posedge clk) disable iff (reset) // RULE_10
		(ee_wr || ee_rd) && busy && !prog_done |=> access_error && program_busy_flag)
		else $error("busy access not aborted");
	row_miss_a: assert property (@(posedge clk) disable iff (reset) // RULE_17
		load_ok == 1'b0 && ee_wr && row_valid_reg && row_reg != ee_row && !busy
		&& program_enable_reg && row_mode_enable_reg && !array_standby
		|=> access_error && $stable(load_mask_reg))
		else $error("other row not refused");
	start_ignore_a: assert property (@(posedge clk) disable iff (reset) // RULE_18
		ctrl_wr && !busy && wd[START_BIT] && !row_mode_enable_reg
		|=> !program_busy_flag && !row_program_start_reg)
		else $error("start accepted without row mode");
	standby_read_a: assert property (@(posedge clk) disable iff (reset) // RULE_01
		ee_rd && array_standby |-> ##2 cpu_rvalid && cpu_rdata == ABORT_DATA)
		else $error("standby read not blanked");
	byte_prog_a: assert property (@(posedge clk) disable iff (reset) // RULE_20
		byte_ok |=> program_busy_flag && load_mask_reg == (8'h01 << $past(ee_lane)))
		else $error("byte write did not start");
endmodule : eew_ctrl

// >>> bench/eew_cpu_model.sv
`timescale 1ns/10ps
module eew_cpu_model
	import eew_pkg::*;
(
	input  wire logic        clk,
	input  wire logic [7:0]  cpu_rdata,
	input  wire logic        cpu_rvalid,
	input  wire logic        access_error,
	output eew_req_type      cpu_req
);
	int err_cnt = 0;

	initial
	begin
		cpu_req = '0;
	end

	// registered pulse, so look mid-cycle rather than at its launching edge
	always @(negedge clk)
	begin
		if (access_error === 1'b1)
			err_cnt <= err_cnt + 1;
	end

	// a released bus shows the inverse, never the stale byte
	task automatic release_bus();
		@(negedge clk);
		cpu_req.wr    = 1'b0;
		cpu_req.rd    = 1'b0;
		cpu_req.addr  = ~cpu_req.addr;
		cpu_req.wdata = ~cpu_req.wdata;
	endtask : release_bus

	task automatic write(input logic sel, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		cpu_req = '{wr: 1'b1, rd: 1'b0, ee_sel: sel, addr: a, wdata: d};
		release_bus();
	endtask : write

	task automatic read(input logic sel, input logic [7:0] a, output logic [7:0] d);
		int n;
		n = 0;
		@(negedge clk);
		cpu_req = '{wr: 1'b0, rd: 1'b1, ee_sel: sel, addr: a, wdata: 8'h00};
		release_bus();
		while (cpu_rvalid !== 1'b1 && n < 4)
		begin
			@(negedge clk);
			n++;
		end
		d = (cpu_rvalid === 1'b1) ? cpu_rdata : 8'hXX;
	endtask : read
endmodule : eew_cpu_model

// >>> bench/eeprom_write_control_bench.sv
`timescale 1ns/10ps
module eeprom_write_control_bench;
	import eew_pkg::*;
	// long enough for the aborted accesses and rejected write to land while busy
	localparam int PCNT = 16;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	eew_req_type cpu_req;
	logic [7:0]  cpu_rdata;
	logic        cpu_rvalid;
	logic        access_error;
	logic        program_busy_flag;
	logic        array_standby;
	int          failures = 0;
	int          check_count = 0;
	int          cycles = 0;
	int          e0;

	always #5 clk = ~clk;

	eew_ctrl #(.PROG_CNT(PCNT)) eew_ctrl_inst (
		.clk(clk), .reset(reset), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
		.cpu_rvalid(cpu_rvalid), .access_error(access_error),
		.program_busy_flag(program_busy_flag), .array_standby(array_standby));

	eew_cpu_model eew_cpu_model_inst (
		.clk(clk), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
		.access_error(access_error), .cpu_req(cpu_req));

	task automatic print_verdict();
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	// whole run needs well under this many cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			print_verdict();
		end
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic wr_c(input logic [7:0] d);
		eew_cpu_model_inst.write(1'b0, CTRL_OFFSET, d);
	endtask : wr_c

	task automatic wr_e(input logic [7:0] a, input logic [7:0] d);
		eew_cpu_model_inst.write(1'b1, a, d);
	endtask : wr_e

	task automatic rd_chk(input logic sel, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		eew_cpu_model_inst.read(sel, a, d);
		check(d, exp);
	endtask : rd_chk

	task automatic busy_rise();
		int n;
		n = 0;
		while (program_busy_flag !== 1'b1 && n < 3)
		begin
			@(negedge clk);
			n++;
		end
		check({7'h00, program_busy_flag}, 8'h01);
	endtask : busy_rise

	task automatic no_busy();
		logic seen;
		seen = 1'b0;
		repeat (6)
		begin
			@(negedge clk);
			if (program_busy_flag !== 1'b0)
				seen = 1'b1;
		end
		check({7'h00, seen}, 8'h00);
	endtask : no_busy

	task automatic wait_idle();
		int n;
		n = 0;
		while (program_busy_flag !== 1'b0 && n < PCNT + 20)
		begin
			@(negedge clk);
			n++;
		end
		check({7'h00, program_busy_flag}, 8'h00);
	endtask : wait_idle

	task automatic err_delta(input logic [7:0] exp);
		@(negedge clk);
		check(8'(eew_cpu_model_inst.err_cnt - e0), exp);
	endtask : err_delta

	task automatic test_reset();
		check({6'h00, array_standby, program_busy_flag}, 8'h00);
		rd_chk(1'b0, CTRL_OFFSET, CTRL_RESET);
		rd_chk(1'b1, 8'h05, ERASED_BYTE);
		$display("test_reset done");
	endtask : test_reset

	task automatic test_byte();
		wr_c(8'h00);
		wr_e(8'h05, 8'h3C);
		no_busy();
		rd_chk(1'b1, 8'h05, ERASED_BYTE);
		wr_c(8'h01);
		wr_e(8'h05, 8'h5A);
		check({7'h00, program_busy_flag}, 8'h01);
		rd_chk(1'b0, CTRL_OFFSET, 8'h02);
		e0 = eew_cpu_model_inst.err_cnt;
		rd_chk(1'b1, 8'h05, ABORT_DATA);
		wr_e(8'h07, 8'h99);
		err_delta(8'h02);
		wr_c(8'h00);
		wait_idle();
		rd_chk(1'b1, 8'h05, 8'h5A);
		rd_chk(1'b1, 8'h07, ERASED_BYTE);
		wr_e(8'h06, 8'hA5);
		busy_rise();
		wait_idle();
		$display("test_byte done");
	endtask : test_byte

	task automatic test_row();
		wr_c(8'h05);
		wr_e(8'h18, 8'h11);
		wr_e(8'h1A, 8'h22);
		wr_e(8'h1B, 8'h33);
		e0 = eew_cpu_model_inst.err_cnt;
		wr_e(8'h20, 8'h44);
		err_delta(8'h01);
		wr_c(8'h0D);
		busy_rise();
		wait_idle();
		rd_chk(1'b1, 8'h18, 8'h11);
		rd_chk(1'b1, 8'h1A, 8'h22);
		rd_chk(1'b1, 8'h1B, 8'h33);
		rd_chk(1'b1, 8'h19, ERASED_BYTE);
		rd_chk(1'b1, 8'h1F, ERASED_BYTE);
		rd_chk(1'b1, 8'h20, ERASED_BYTE);
		wr_e(8'h21, 8'h66);
		busy_rise();
		wait_idle();
		rd_chk(1'b1, 8'h21, 8'h66);
		wr_c(8'h05);
		wr_e(8'h2A, 8'h77);
		wr_c(8'h0D);
		busy_rise();
		wait_idle();
		rd_chk(1'b1, 8'h2A, 8'h77);
		rd_chk(1'b1, 8'h28, ERASED_BYTE);
		rd_chk(1'b1, 8'h2B, ERASED_BYTE);
		$display("test_row done");
	endtask : test_row

	task automatic test_abandon();
		wr_c(8'h05);
		wr_e(8'h30, 8'h12);
		wr_c(8'h01);
		no_busy();
		wr_c(8'h09);
		no_busy();
		wr_c(8'h0C);
		no_busy();
		rd_chk(1'b1, 8'h30, ERASED_BYTE);
		$display("test_abandon done");
	endtask : test_abandon

	task automatic test_standby();
		wr_c(8'h40);
		check({7'h00, array_standby}, 8'h01);
		e0 = eew_cpu_model_inst.err_cnt;
		rd_chk(1'b1, 8'h05, ABORT_DATA);
		err_delta(8'h01);
		wr_c(8'h01);
		check({7'h00, array_standby}, 8'h00);
		rd_chk(1'b1, 8'h05, 8'h5A);
		$display("test_standby done");
	endtask : test_standby

	initial
	begin
		repeat (10) @(negedge clk);
		reset = 1'b0;
		test_reset();
		test_byte();
		test_row();
		test_abandon();
		test_standby();
		print_verdict();
	end
endmodule : eeprom_write_control_bench
